// *** inc/ccr_pkg.sv ***
// Purpose: Shared constants and types for the card configuration registers
// Assumes: Eight-bit registers on the low data byte, even attribute addresses
// Notes: Offsets are attribute memory byte addresses
package ccr_pkg;
  // Register offsets
  localparam logic [9:0] CCR_OFS_OPTION = 10'h200;
  localparam logic [9:0] CCR_OFS_STATUS = 10'h202;
  localparam logic [9:0] CCR_OFS_PINREP = 10'h204;
  localparam logic [9:0] CCR_OFS_SOCKET = 10'h206;
  // Configuration option fields
  localparam int COR_CARD_SOFT_RESET_BIT = 7;
  localparam int COR_LEVEL_BIT = 6;
  localparam int COR_INDEX_LSB = 0;
  localparam int COR_INDEX_W = 6;
  // Configuration and status fields
  localparam int CCSR_CHANGED_BIT = 7;
  localparam int CCSR_STATUS_CHANGE_ENABLE_BIT = 6;
  localparam int CCSR_BYTE_IO_REQUEST_BIT = 5;
  localparam int CCSR_POWER_DOWN_REQUEST_BIT = 2;
  localparam int CCSR_INT_BIT = 1;
  // Pin replacement fields
  localparam int PRR_READY_CHANGE_LATCH_BIT = 5;
  localparam int PRR_RREADY_BIT = 1;
  localparam logic [7:0] PRR_ONES = 8'h0C;
  // Socket and copy fields
  localparam int SCR_DRIVE_BIT = 4;
  // Reset values
  localparam logic [5:0] CFG_INDEX_RESET = 6'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  // Configuration index encodings
  localparam logic [5:0] CFG_MEMORY = 6'h00;
  localparam logic [5:0] CFG_IO_ANY = 6'h01;
  localparam logic [5:0] CFG_IO_PRI = 6'h02;
  localparam logic [5:0] CFG_IO_SEC = 6'h03;
  localparam logic [9:0] IO_PRI_BASE = 10'h1F0;
  localparam logic [9:0] IO_SEC_BASE = 10'h170;
  localparam logic [9:0] IO_ANY_BASE = 10'h000;
  // Power state walk, Gray coded
  typedef enum logic [1:0] {
    CCR_PWR_ACTIVE = 2'h0,
    CCR_PWR_GOING_LOW = 2'h1,
    CCR_PWR_LOW = 2'h3,
    CCR_PWR_GOING_UP = 2'h2
  } ccr_pwr_type;
endpackage

// *** hw/ccr_card_config.sv ***
// Purpose: Attribute memory configuration registers of a removable storage card
// Assumes: Host strobes sampled as synchronous inputs on i_clk
// Notes: Write taken on the falling edge of i_we_n, read data one cycle later
// Behaviour
// - Soft reset bit holds card in reset
// - Soft reset never self clears; leaves unconfigured
// - Soft reset counts as ATA hard reset
// - Level select bit chooses level/pulse interrupts
// - Six-bit index selects memory or I/O decode
// - Changed bit reads latch OR
// - Status change pin low when changed, enabled, I/O index only
// - Byte I/O request bit has no effect
// - Power-down bit change forces busy until reached
// - Auto power-down when idle, wake on command
// - Interrupt bit mirrors internal request
// - Interrupt bit reads zero when disabled
// - Live ready bit; bits three, two read one
// - Ready-change latch sets on ready toggle
// - Latch written only when mask bit set
// - Ultra DMA write strobe mapping, word per edge
// - Ultra DMA read strobe mapping, word per edge
// - True IDE only with output enable grounded
`timescale 1ns/100ps
module ccr_card_config (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_reg_n,
  input wire logic i_ce1_n,
  input wire logic [9:0] i_addr,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rdata_oe,
  input wire logic i_ready_core,
  input wire logic i_wp_state,
  input wire logic i_irq_req,
  input wire logic i_irq_disable_bit,
  input wire logic i_idle,
  input wire logic i_cmd_arrive,
  input wire logic i_lowpower_ack,
  output logic o_lowpower_req,
  output logic o_ready_irq_pin,
  output logic o_status_change_pin_n,
  output logic o_core_hard_reset,
  output logic o_true_ide,
  output logic o_io_mode,
  output logic [9:0] o_io_base,
  output logic [5:0] o_cfg_index,
  input wire logic i_udma_active,
  input wire logic i_udma_read,
  input wire logic i_iord_n,
  input wire logic i_iowr_n,
  input wire logic i_dev_iordy,
  output logic o_hstrobe,
  output logic o_hdmardy_n,
  output logic o_stop,
  output logic o_iordy,
  output logic o_word_strobe
);

  typedef struct packed {
    logic [5:0] cfg_index;
    logic level_irq;
    logic card_soft_reset;
    logic status_change_pin_en;
    logic byte_io;
    logic power_down_request;
    logic rdy_chg;
    logic wp_chg;
    logic auto_sleep;
    ccr_pkg::ccr_pwr_type pwr;
    logic we_n_d;
    logic live_rdy_d;
    logic wp_d;
    logic irq_d;
    logic strobe_d;
    logic strap_done;
    logic ide_mode;
    logic [7:0] rdata;
    logic status_change_pin_n;
    logic irq_pin;
    logic word_pulse;
  } ccr_state_type;

  ccr_state_type state_reg;
  ccr_state_type state_next;

  logic hit_option;
  logic hit_status;
  logic hit_pinrep;
  logic hit_socket;
  logic wr_take;
  logic rd_take;
  logic pwr_busy;
  logic live_rdy;
  logic int_bit;
  logic changed;
  logic target_low;
  logic sel_strobe;

  // Attribute register hit on the low byte, even address only
  function automatic logic cfg_hit(input logic [9:0] addr, input logic [9:0] ofs,
      input logic reg_n, input logic ce1_n, input logic ide);
    cfg_hit = !reg_n && !ce1_n && !ide && (addr == ofs);
  endfunction

  always_comb begin
    hit_option = cfg_hit(i_addr, ccr_pkg::CCR_OFS_OPTION, i_reg_n, i_ce1_n, state_reg.ide_mode);
    hit_status = cfg_hit(i_addr, ccr_pkg::CCR_OFS_STATUS, i_reg_n, i_ce1_n, state_reg.ide_mode);
    hit_pinrep = cfg_hit(i_addr, ccr_pkg::CCR_OFS_PINREP, i_reg_n, i_ce1_n, state_reg.ide_mode);
    hit_socket = cfg_hit(i_addr, ccr_pkg::CCR_OFS_SOCKET, i_reg_n, i_ce1_n, state_reg.ide_mode);
    wr_take = !i_we_n && state_reg.we_n_d;
    rd_take = !i_oe_n && i_we_n;
    pwr_busy = (state_reg.pwr == ccr_pkg::CCR_PWR_GOING_LOW) ||
      (state_reg.pwr == ccr_pkg::CCR_PWR_GOING_UP);
    live_rdy = i_ready_core && !pwr_busy && !state_reg.card_soft_reset;
    int_bit = i_irq_req && !i_irq_disable_bit;
    changed = state_reg.rdy_chg || state_reg.wp_chg;
    target_low = state_reg.power_down_request || state_reg.auto_sleep;
    sel_strobe = i_udma_read ? i_dev_iordy : i_iord_n;
  end

  always_comb begin
    state_next = state_reg;
    state_next.we_n_d = i_we_n;
    state_next.live_rdy_d = live_rdy;
    state_next.wp_d = i_wp_state;
    state_next.irq_d = int_bit;
    state_next.strobe_d = sel_strobe;
    // Strap caught once, the first cycle after reset release
    if (!state_reg.strap_done) begin
      state_next.strap_done = 1'b1;
      state_next.ide_mode = !i_oe_n;
    end
    if (live_rdy != state_reg.live_rdy_d) begin
      state_next.rdy_chg = 1'b1;
    end
    if (i_wp_state != state_reg.wp_d) begin
      state_next.wp_chg = 1'b1;
    end
    if (i_idle) begin
      state_next.auto_sleep = 1'b1;
    end
    if (i_cmd_arrive) begin
      state_next.auto_sleep = 1'b0;
    end
    if (wr_take && hit_option) begin
      state_next.card_soft_reset = i_wdata[ccr_pkg::COR_CARD_SOFT_RESET_BIT];
      if (!state_reg.card_soft_reset && !i_wdata[ccr_pkg::COR_CARD_SOFT_RESET_BIT]) begin
        state_next.level_irq = i_wdata[ccr_pkg::COR_LEVEL_BIT];
        state_next.cfg_index =
          i_wdata[ccr_pkg::COR_INDEX_LSB +: ccr_pkg::COR_INDEX_W];
      end
    end
    if (wr_take && hit_status) begin
      state_next.status_change_pin_en = i_wdata[ccr_pkg::CCSR_STATUS_CHANGE_ENABLE_BIT];
      // Stored for read-back only; both access widths stay supported
      state_next.byte_io = i_wdata[ccr_pkg::CCSR_BYTE_IO_REQUEST_BIT];
      state_next.power_down_request = i_wdata[ccr_pkg::CCSR_POWER_DOWN_REQUEST_BIT];
    end
    if (wr_take && hit_pinrep && i_wdata[ccr_pkg::PRR_RREADY_BIT]) begin
      // A toggle in the same cycle still sets the latch
      state_next.rdy_chg = i_wdata[ccr_pkg::PRR_READY_CHANGE_LATCH_BIT] ||
        (live_rdy != state_reg.live_rdy_d);
    end
    unique case (state_reg.pwr)
      ccr_pkg::CCR_PWR_ACTIVE: begin
        if (target_low) begin
          state_next.pwr = ccr_pkg::CCR_PWR_GOING_LOW;
        end
      end
      ccr_pkg::CCR_PWR_GOING_LOW: begin
        if (i_lowpower_ack) begin
          state_next.pwr = ccr_pkg::CCR_PWR_LOW;
        end
      end
      ccr_pkg::CCR_PWR_LOW: begin
        if (!target_low) begin
          state_next.pwr = ccr_pkg::CCR_PWR_GOING_UP;
        end
      end
      ccr_pkg::CCR_PWR_GOING_UP: begin
        if (!i_lowpower_ack) begin
          state_next.pwr = ccr_pkg::CCR_PWR_ACTIVE;
        end
      end
    endcase
    // Card stays unconfigured while soft reset is held
    if (state_reg.card_soft_reset) begin
      state_next.cfg_index = ccr_pkg::CFG_INDEX_RESET;
      state_next.level_irq = 1'b0;
      state_next.status_change_pin_en = 1'b0;
      state_next.byte_io = 1'b0;
      state_next.power_down_request = 1'b0;
    end
    state_next.rdata = ccr_pkg::RDATA_RESET;
    if (rd_take && hit_option) begin
      state_next.rdata = {state_reg.card_soft_reset, state_reg.level_irq, state_reg.cfg_index};
    end
    if (rd_take && hit_status) begin
      state_next.rdata[ccr_pkg::CCSR_CHANGED_BIT] = changed;
      state_next.rdata[ccr_pkg::CCSR_STATUS_CHANGE_ENABLE_BIT] = state_reg.status_change_pin_en;
      state_next.rdata[ccr_pkg::CCSR_BYTE_IO_REQUEST_BIT] = state_reg.byte_io;
      state_next.rdata[ccr_pkg::CCSR_POWER_DOWN_REQUEST_BIT] = state_reg.power_down_request;
      state_next.rdata[ccr_pkg::CCSR_INT_BIT] = int_bit;
    end
    if (rd_take && hit_pinrep) begin
      state_next.rdata = ccr_pkg::PRR_ONES;
      state_next.rdata[ccr_pkg::PRR_READY_CHANGE_LATCH_BIT] = state_reg.rdy_chg;
      state_next.rdata[ccr_pkg::PRR_RREADY_BIT] = live_rdy;
    end
    // Socket register reads all zero, drive bit included
    if (rd_take && hit_socket) begin
      state_next.rdata[ccr_pkg::SCR_DRIVE_BIT] = 1'b0;
    end
    if (state_reg.cfg_index == ccr_pkg::CFG_MEMORY) begin
      state_next.status_change_pin_n = 1'b1;
      state_next.irq_pin = live_rdy;
    end else begin
      state_next.status_change_pin_n = !(changed && state_reg.status_change_pin_en);
      if (state_reg.level_irq) begin
        state_next.irq_pin = !int_bit;
      end else begin
        state_next.irq_pin = !(int_bit && !state_reg.irq_d);
      end
    end
    state_next.word_pulse = i_udma_active && (sel_strobe != state_reg.strobe_d);
    if (i_rst) begin
      state_next = '0;
      state_next.we_n_d = 1'b1;
      // Edge detectors start at the live levels, so no false change follows reset
      state_next.live_rdy_d = i_ready_core;
      state_next.wp_d = i_wp_state;
      state_next.strobe_d = sel_strobe;
      state_next.status_change_pin_n = 1'b1;
      state_next.irq_pin = 1'b1;
      state_next.pwr = ccr_pkg::CCR_PWR_ACTIVE;
      state_next.cfg_index = ccr_pkg::CFG_INDEX_RESET;
    end
  end

  always_ff @(posedge i_clk) begin
    state_reg <= state_next;
  end

  always_comb begin
    o_rdata = state_reg.rdata;
    o_rdata_oe = !i_oe_n && (hit_option || hit_status || hit_pinrep || hit_socket);
    o_lowpower_req = state_reg.pwr[0];
    o_ready_irq_pin = state_reg.irq_pin;
    o_status_change_pin_n = state_reg.status_change_pin_n;
    o_core_hard_reset = state_reg.card_soft_reset;
    o_true_ide = state_reg.ide_mode;
    o_io_mode = state_reg.cfg_index != ccr_pkg::CFG_MEMORY;
    o_cfg_index = state_reg.cfg_index;
    unique case (state_reg.cfg_index)
      ccr_pkg::CFG_IO_PRI: o_io_base = ccr_pkg::IO_PRI_BASE;
      ccr_pkg::CFG_IO_SEC: o_io_base = ccr_pkg::IO_SEC_BASE;
      default: o_io_base = ccr_pkg::IO_ANY_BASE;
    endcase
    o_hstrobe = i_udma_active && !i_udma_read && i_iord_n;
    o_hdmardy_n = i_udma_active && i_udma_read ? i_iord_n : 1'b1;
    o_stop = i_udma_active && i_iowr_n;
    o_iordy = i_dev_iordy;
    o_word_strobe = state_reg.word_pulse;
  end

  property p_card_soft_reset_set;
    @(posedge i_clk) disable iff (i_rst)
      (wr_take && hit_option && i_wdata[7]) |=> o_core_hard_reset;
  endproperty
  a_card_soft_reset_set: assert property (p_card_soft_reset_set) else $error("soft reset not applied");

  property p_card_soft_reset_unconfig;
    @(posedge i_clk) disable iff (i_rst)
      state_reg.card_soft_reset |=> (o_cfg_index == 6'h00) && !state_reg.level_irq;
  endproperty
  a_card_soft_reset_unconfig: assert property (p_card_soft_reset_unconfig) else $error("config kept in reset");

  property p_reset_clears;
    @(posedge i_clk) i_rst |=> (o_cfg_index == 6'h00) && !state_reg.level_irq && !o_core_hard_reset;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset values wrong");

  property p_changed_read;
    @(posedge i_clk) disable iff (i_rst)
      (rd_take && hit_status && (state_reg.rdy_chg || state_reg.wp_chg)) |=> o_rdata[7];
  endproperty
  a_changed_read: assert property (p_changed_read) else $error("changed bit not set");

  property p_status_change_pin_pin;
    @(posedge i_clk) disable iff (i_rst)
      (o_io_mode && changed && state_reg.status_change_pin_en) |=> !o_status_change_pin_n;
  endproperty
  a_status_change_pin_pin: assert property (p_status_change_pin_pin) else $error("status change pin not low");

  property p_pwr_busy;
    @(posedge i_clk) disable iff (i_rst)
      (state_reg.pwr == ccr_pkg::CCR_PWR_ACTIVE && target_low && !state_reg.card_soft_reset)
        |=> !live_rdy ##1 ($past(i_lowpower_ack) || !live_rdy);
  endproperty
  a_pwr_busy: assert property (p_pwr_busy) else $error("ready during power change");

  property p_int_masked;
    @(posedge i_clk) disable iff (i_rst)
      (rd_take && hit_status && i_irq_disable_bit) |=> !o_rdata[1];
  endproperty
  a_int_masked: assert property (p_int_masked) else $error("int bit not masked");

  property p_pinrep_ones;
    @(posedge i_clk) disable iff (i_rst)
      (rd_take && hit_pinrep) |=> (o_rdata[3:2] == 2'b11) && (o_rdata[1] == $past(live_rdy));
  endproperty
  a_pinrep_ones: assert property (p_pinrep_ones) else $error("pin replacement read wrong");

  property p_mask_keep;
    @(posedge i_clk) disable iff (i_rst)
      (wr_take && hit_pinrep && !i_wdata[1] && live_rdy == state_reg.live_rdy_d)
        |=> state_reg.rdy_chg == $past(state_reg.rdy_chg);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("latch changed without mask");

  property p_socket_zero;
    @(posedge i_clk) disable iff (i_rst)
      (rd_take && hit_socket) |=> o_rdata == 8'h00;
  endproperty
  a_socket_zero: assert property (p_socket_zero) else $error("socket register not zero");

  property p_word_pulse;
    @(posedge i_clk) disable iff (i_rst)
      (i_udma_active && (sel_strobe != state_reg.strobe_d)) |=> o_word_strobe;
  endproperty
  a_word_pulse: assert property (p_word_pulse) else $error("strobe edge lost");

  property p_level_irq;
    @(posedge i_clk) disable iff (i_rst)
      (o_io_mode && state_reg.level_irq && int_bit) |=> !o_ready_irq_pin;
  endproperty
  a_level_irq: assert property (p_level_irq) else $error("level interrupt not low");

  property p_pulse_irq;
    @(posedge i_clk) disable iff (i_rst)
      (o_io_mode && !state_reg.level_irq && int_bit && state_reg.irq_d) |=> o_ready_irq_pin;
  endproperty
  a_pulse_irq: assert property (p_pulse_irq) else $error("pulse interrupt held low");

endmodule // ccr_card_config

// *** tb/ccr_host_model.sv ***
// Purpose: Host controller model for attribute register cycles
// Assumes: Lines change at the falling clock edge
// Notes: Released write data shows the inverse of the last byte
`timescale 1ns/100ps
module ccr_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_oe,
  output logic o_reg_n,
  output logic o_ce1_n,
  output logic [9:0] o_addr,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [7:0] o_wdata
);
  logic oe_seen;
  initial begin
    oe_seen = 1'b0;
    o_reg_n = 1'b1;
    o_ce1_n = 1'b1;
    o_addr = 10'h3FF;
    o_oe_n = 1'b1;
    o_we_n = 1'b1;
    o_wdata = 8'hA5;
  end
  // Strap level held over reset release
  task automatic strap(input logic v);
    o_oe_n = v;
  endtask
  // One byte write, strobe high again before the next
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic rg);
    @(negedge i_clk);
    o_reg_n = rg;
    o_ce1_n = 1'b0;
    o_addr = a;
    o_wdata = d;
    o_we_n = 1'b0;
    @(negedge i_clk);
    o_we_n = 1'b1;
    @(negedge i_clk);
    o_reg_n = 1'b1;
    o_ce1_n = 1'b1;
    o_wdata = ~d;
  endtask
  // Read data taken two cycles after the read edge
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_reg_n = 1'b0;
    o_ce1_n = 1'b0;
    o_addr = a;
    o_oe_n = 1'b0;
    repeat (2) @(negedge i_clk);
    d = i_rdata;
    oe_seen = i_rdata_oe;
    o_oe_n = 1'b1;
    o_reg_n = 1'b1;
    o_ce1_n = 1'b1;
  endtask
endmodule // ccr_host_model

// *** tb/tb_ccr_card_config.sv ***
// Purpose: Self-checking bench for the card configuration registers
// Assumes: Inputs driven at the falling edge, fixed seed
// Notes: Host cycles come from the host model instance
`timescale 1ns/100ps
module tb_ccr_card_config;
  logic i_clk, i_rst, i_reg_n, i_ce1_n, i_oe_n, i_we_n, lvl;
  logic [9:0] i_addr, o_io_base;
  logic [7:0] i_wdata, o_rdata, rv;
  logic [5:0] o_cfg_index;
  logic i_ready_core, i_wp_state, i_irq_req, i_irq_disable_bit, i_idle, i_cmd_arrive;
  logic i_lowpower_ack, i_udma_active, i_udma_read, i_iord_n, i_iowr_n, i_dev_iordy;
  logic o_rdata_oe, o_lowpower_req, o_ready_irq_pin, o_status_change_pin_n;
  logic o_core_hard_reset, o_true_ide, o_io_mode, o_hstrobe, o_hdmardy_n, o_stop;
  logic o_iordy, o_word_strobe;
  int error_cnt, tests_run, seed, cnt;
  ccr_card_config i_ccr_card_config (.i_clk, .i_rst, .i_reg_n, .i_ce1_n, .i_addr, .i_oe_n,
    .i_we_n, .i_wdata, .o_rdata, .o_rdata_oe, .i_ready_core, .i_wp_state, .i_irq_req,
    .i_irq_disable_bit, .i_idle, .i_cmd_arrive, .i_lowpower_ack, .o_lowpower_req,
    .o_ready_irq_pin, .o_status_change_pin_n, .o_core_hard_reset, .o_true_ide, .o_io_mode,
    .o_io_base, .o_cfg_index, .i_udma_active, .i_udma_read, .i_iord_n, .i_iowr_n,
    .i_dev_iordy, .o_hstrobe, .o_hdmardy_n, .o_stop, .o_iordy, .o_word_strobe);
  ccr_host_model i_ccr_host_model (.i_clk(i_clk), .i_rdata(o_rdata),
    .i_rdata_oe(o_rdata_oe), .o_reg_n(i_reg_n),
    .o_ce1_n(i_ce1_n), .o_addr(i_addr), .o_oe_n(i_oe_n), .o_we_n(i_we_n),
    .o_wdata(i_wdata));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("counts: %0d compared, %0d mismatched", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    i_ccr_host_model.rd(a, rv);
    chk(rv, exp);
    chk(i_ccr_host_model.oe_seen, 1'(a inside {10'h200, 10'h202, 10'h204, 10'h206}));
  endtask
  task automatic wait_lp(input logic v);
    for (int k = 0; k < 50 && o_lowpower_req !== v; k++) @(negedge i_clk);
    chk(o_lowpower_req, v);
    if (o_lowpower_req !== v) wrap_up();
  endtask
  task automatic do_reset(input logic ide);
    @(negedge i_clk);
    i_rst = 1'b1;
    i_ccr_host_model.strap(~ide);
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    i_ccr_host_model.strap(1'b1);
  endtask
  task automatic udma(input logic act, input logic rdir);
    cnt = 0;
    @(negedge i_clk);
    i_udma_active = act;
    i_udma_read = rdir;
    i_iowr_n = 1'b0;
    repeat (6) begin
      @(negedge i_clk);
      if (rdir) i_dev_iordy = ~i_dev_iordy;
      else i_iord_n = ~i_iord_n;
      repeat (3) begin
        @(negedge i_clk);
        cnt += int'(o_word_strobe === 1'b1);
      end
    end
  endtask
  function automatic logic [9:0] exp_base(input logic [5:0] idx);
    case (idx)
      6'h02: return 10'h1F0;
      6'h03: return 10'h170;
      default: return 10'h000;
    endcase
  endfunction
  initial begin
    seed = 38;
    {i_rst, i_ready_core, i_iord_n, i_iowr_n} = 4'hF;
    {i_wp_state, i_irq_req, i_irq_disable_bit, i_idle, i_cmd_arrive} = 5'h00;
    {i_lowpower_ack, i_udma_active, i_udma_read, i_dev_iordy} = 4'h0;
    do_reset(1'b0);
    chk(o_true_ide, 1'b0);
    chk(o_status_change_pin_n, 1'b1);
    chk(o_ready_irq_pin, 1'b1);
    rchk(10'h200, 8'h00);
    rchk(10'h204, 8'h0E);
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      lvl = 1'($random(seed));
      i_ccr_host_model.wr(10'h206, {4'h0, 4'($random(seed))}, 1'b0);
      rchk(10'h206, 8'h00);
      i_ccr_host_model.wr(10'h200, {1'b0, lvl, 6'(k)}, 1'b0);
      rchk(10'h200, {1'b0, lvl, 6'(k)});
      chk(o_io_base, exp_base(6'(k)));
      chk(o_io_mode, 1'(k != 0));
    end
    $display("test index modes done");
    i_ccr_host_model.wr(10'h202, 8'h60, 1'b0);
    rchk(10'h202, 8'h60);
    chk(o_status_change_pin_n, 1'b1);
    i_ready_core = 1'b0;
    repeat (3) @(negedge i_clk);
    rchk(10'h204, 8'h2C);
    rchk(10'h202, 8'hE0);
    chk(o_status_change_pin_n, 1'b0);
    i_ccr_host_model.wr(10'h204, 8'h00, 1'b0);
    rchk(10'h204, 8'h2C);
    i_ccr_host_model.wr(10'h204, 8'h02, 1'b0);
    rchk(10'h204, 8'h0C);
    chk(o_status_change_pin_n, 1'b1);
    i_ccr_host_model.wr(10'h202, 8'h00, 1'b0);
    i_wp_state = 1'b1;
    repeat (3) @(negedge i_clk);
    rchk(10'h202, 8'h80);
    chk(o_status_change_pin_n, 1'b1);
    $display("test change latches done");
    i_ccr_host_model.wr(10'h200, 8'h43, 1'b0);
    i_irq_req = 1'b1;
    repeat (3) @(negedge i_clk);
    rchk(10'h202, 8'h82);
    chk(o_ready_irq_pin, 1'b0);
    i_irq_disable_bit = 1'b1;
    rchk(10'h202, 8'h80);
    {i_irq_req, i_irq_disable_bit} = 2'b00;
    i_ccr_host_model.wr(10'h200, 8'h03, 1'b0);
    cnt = 0;
    i_irq_req = 1'b1;
    repeat (10) @(negedge i_clk) cnt += int'(o_ready_irq_pin === 1'b0);
    chk(10'(cnt), 10'h001);
    i_irq_req = 1'b0;
    $display("test interrupt done");
    i_ready_core = 1'b1;
    i_ccr_host_model.wr(10'h202, 8'h04, 1'b0);
    wait_lp(1'b1);
    rchk(10'h204, 8'h2C);
    i_lowpower_ack = 1'b1;
    repeat (3) @(negedge i_clk);
    rchk(10'h204, 8'h2E);
    rchk(10'h202, 8'h84);
    i_lowpower_ack = 1'b0;
    i_ccr_host_model.wr(10'h202, 8'h00, 1'b0);
    wait_lp(1'b0);
    @(negedge i_clk) i_idle = 1'b1;
    @(negedge i_clk) i_idle = 1'b0;
    wait_lp(1'b1);
    i_lowpower_ack = 1'b1;
    @(negedge i_clk) i_cmd_arrive = 1'b1;
    @(negedge i_clk) i_cmd_arrive = 1'b0;
    i_lowpower_ack = 1'b0;
    wait_lp(1'b0);
    $display("test power done");
    i_ccr_host_model.wr(10'h200, 8'h83, 1'b0);
    repeat (20) @(negedge i_clk);
    chk(o_core_hard_reset, 1'b1);
    i_ccr_host_model.rd(10'h200, rv);
    chk(rv[7], 1'b1);
    i_ccr_host_model.wr(10'h200, 8'h00, 1'b0);
    rchk(10'h200, 8'h00);
    chk(o_cfg_index, 6'h00);
    chk(o_core_hard_reset, 1'b0);
    i_ccr_host_model.wr(10'h200, 8'h02, 1'b1);
    i_ccr_host_model.wr(10'h201, 8'h02, 1'b0);
    chk(o_cfg_index, 6'h00);
    rchk(10'h208, 8'h00);
    $display("test soft reset and decode done");
    udma(1'b1, 1'b0);
    chk(10'(cnt), 10'h006);
    chk(o_hstrobe, i_iord_n);
    chk(o_stop, 1'b0);
    udma(1'b1, 1'b1);
    chk(10'(cnt), 10'h006);
    chk(o_iordy, i_dev_iordy);
    chk(o_hdmardy_n, i_iord_n);
    i_iowr_n = 1'b1;
    @(negedge i_clk);
    chk(o_stop, 1'b1);
    udma(1'b0, 1'b0);
    chk(10'(cnt), 10'h000);
    i_iowr_n = 1'b1;
    $display("test ultra dma done");
    do_reset(1'b1);
    chk(o_true_ide, 1'b1);
    i_ccr_host_model.wr(10'h200, 8'h01, 1'b0);
    chk(o_cfg_index, 6'h00);
    $display("test strap done");
    wrap_up();
  end
endmodule // tb_ccr_card_config
